// >>> core/tim_pkg.sv
// Overview of operation
// - read, prefetch and write counts are reported and lie inside the total.
// - worst case arithmetic and logical figures include one next-word prefetch.
// - multiple register load takes 8+4n, or 9+4n worst, one read each.
// - multiple register store takes 4+3n best and cache, n writes, no reads.
// - worst case multiple register store takes 5+3n with one prefetch.
// - n equals the number of registers selected in the register list operand.
// - marked arithmetic entries add operand or immediate fetch addressing time.
// - multiple register and alternate space move_alternate_space add immediate address calculation time.
// - status word store adds effective address calculation to 5 best, 7 worst.
// - immediate operations cover immediate fetch and the destination operation.
package tim_pkg;
  localparam int TIM_LIST_W = 16;
  localparam int TIM_CNT_W = 5;
  localparam int TIM_CLK_W = 10;
  localparam int TIM_ADDR_W = 8;

  typedef enum logic [1:0] {
    TIM_CASE_BEST = 2'h0,
    TIM_CASE_CACHE = 2'h1,
    TIM_CASE_WORST = 2'h2
  } tim_case_type;

  typedef enum logic [2:0] {
    TIM_ADDR_NONE = 3'h0,
    TIM_ADDR_FETCH_EA = 3'h1,
    TIM_ADDR_FETCH_IMM = 3'h2,
    TIM_ADDR_CALC_EA = 3'h3,
    TIM_ADDR_CALC_IMM = 3'h4
  } tim_addr_type;

  typedef enum logic [4:0] {
    TIM_F_EXCHANGE, TIM_F_CTL_TO_REG, TIM_F_REG_TO_CTL, TIM_F_PSW_TO_REG,
    TIM_F_PSW_TO_MEM, TIM_F_EA_TO_CCB, TIM_F_EA_TO_SRF, TIM_F_MMR_LOAD,
    TIM_F_MMR_STORE, TIM_F_PERIPH_W_STORE, TIM_F_PERIPH_L_STORE, TIM_F_PERIPH_W_LOAD,
    TIM_F_PERIPH_L_LOAD, TIM_F_ALT_LOAD, TIM_F_ALT_STORE, TIM_F_USER_SP,
    TIM_F_SWAP, TIM_F_ALU_TO_REG, TIM_F_ALU_TO_MEM, TIM_F_CMP_ADDR,
    TIM_F_CMP_BOUNDS, TIM_F_MUL_W, TIM_F_MUL_L, TIM_F_DIVU_W,
    TIM_F_DIVU_L, TIM_F_DIVS_W, TIM_F_DIVS_L, TIM_F_QUICK_TO_REG,
    TIM_F_QUICK_TO_MEM, TIM_F_IMM_TO_REG, TIM_F_IMM_TO_MEM, TIM_F_IMM_COMPARE
  } tim_form_type;

  typedef struct packed {
    logic [7:0] best;
    logic [7:0] cache;
    logic [7:0] worst;
    logic [2:0] reads;
    logic [2:0] writes;
    logic [1:0] pf_worst;
    logic [2:0] per_reg_clk;
    logic rd_per_reg;
    logic wr_per_reg;
    tim_addr_type addr_kind;
  } tim_entry_type;

  typedef struct packed {
    tim_form_type form;
    tim_case_type case_sel;
    logic [TIM_LIST_W-1:0] reg_list;
    logic [TIM_ADDR_W-1:0] addr_clocks;
  } tim_req_type;

  typedef struct packed {
    logic [TIM_CLK_W-1:0] total;
    logic [TIM_CNT_W-1:0] reads;
    logic [2:0] prefetches;
    logic [TIM_CNT_W-1:0] writes;
    tim_addr_type addr_kind;
  } tim_result_type;

  // best, cache, worst, reads, writes, worst prefetches, clocks per register, per-register read/write, addressing
  localparam tim_entry_type TIM_TABLE [32] = '{
    '{8'h00, 8'h02, 8'h03, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_NONE},
    '{8'h03, 8'h06, 8'h07, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_NONE},
    '{8'h09, 8'h0C, 8'h0D, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_NONE},
    '{8'h01, 8'h04, 8'h05, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_NONE},
    '{8'h05, 8'h05, 8'h07, 3'h0, 3'h1, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_CALC_EA},
    '{8'h04, 8'h04, 8'h05, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_EA},
    '{8'h08, 8'h08, 8'h0B, 3'h0, 3'h0, 2'h2, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_EA},
    '{8'h08, 8'h08, 8'h09, 3'h0, 3'h0, 2'h1, 3'h4, 1'h1, 1'h0, TIM_ADDR_CALC_IMM},
    '{8'h04, 8'h04, 8'h05, 3'h0, 3'h0, 2'h1, 3'h3, 1'h0, 1'h1, TIM_ADDR_CALC_IMM},
    '{8'h08, 8'h0B, 8'h0B, 3'h0, 3'h2, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_NONE},
    '{8'h0E, 8'h11, 8'h11, 3'h0, 3'h4, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_NONE},
    '{8'h0A, 8'h0C, 8'h0C, 3'h2, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_NONE},
    '{8'h10, 8'h12, 8'h12, 3'h4, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_NONE},
    '{8'h07, 8'h07, 8'h08, 3'h1, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_CALC_IMM},
    '{8'h05, 8'h05, 8'h07, 3'h0, 3'h1, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_CALC_IMM},
    '{8'h00, 8'h02, 8'h03, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_NONE},
    '{8'h01, 8'h04, 8'h04, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_NONE},
    '{8'h00, 8'h02, 8'h03, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_EA},
    '{8'h03, 8'h04, 8'h06, 3'h0, 3'h1, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_EA},
    '{8'h01, 8'h04, 8'h04, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_EA},
    '{8'h10, 8'h12, 8'h12, 3'h1, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_IMM},
    '{8'h19, 8'h1B, 8'h1C, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_EA},
    '{8'h29, 8'h2B, 8'h2C, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_IMM},
    '{8'h2A, 8'h2C, 8'h2C, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_EA},
    '{8'h4C, 8'h4E, 8'h4F, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_IMM},
    '{8'h36, 8'h38, 8'h39, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_EA},
    '{8'h58, 8'h5A, 8'h5B, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_IMM},
    '{8'h00, 8'h02, 8'h03, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_NONE},
    '{8'h03, 8'h04, 8'h06, 3'h0, 3'h1, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_EA},
    '{8'h00, 8'h02, 8'h03, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_IMM},
    '{8'h03, 8'h04, 8'h06, 3'h0, 3'h1, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_IMM},
    '{8'h00, 8'h02, 8'h03, 3'h0, 3'h0, 2'h1, 3'h0, 1'h0, 1'h0, TIM_ADDR_FETCH_IMM}
  };
endpackage

// >>> core/tim_reg_count.sv
`timescale 1ns/10ps
module tim_reg_count #(
  parameter int WIDTH = 16,
  parameter int CNT_W = 5
) (
  // register list in, selected count out
  input wire logic [WIDTH-1:0] reg_list,
  output logic [CNT_W-1:0] count
);
  always_comb begin
    count = '0;
    for (int i = 0; i < WIDTH; i++) begin
      count = count + CNT_W'(reg_list[i]);
    end
  end
endmodule

// >>> core/tim_cycle_model.sv
`timescale 1ns/10ps
module tim_cycle_model
  import tim_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // request
  input wire logic req_valid,
  input wire tim_req_type req_in,
  output logic req_ready,
  // result
  output logic result_valid,
  output tim_result_type result
);
  typedef enum logic [2:0] {
    TIM_ST_IDLE = 3'b001,
    TIM_ST_LOOKUP = 3'b010,
    TIM_ST_REPORT = 3'b100
  } tim_state_type;

  tim_state_type state_reg, state_next;
  tim_req_type req_reg;
  tim_result_type result_reg, result_next;
  logic [TIM_CNT_W-1:0] reg_count;

  tim_reg_count #(.WIDTH(TIM_LIST_W), .CNT_W(TIM_CNT_W)) u_count (
    .reg_list(req_reg.reg_list),
    .count(reg_count)
  );

  wire tim_entry_type entry = TIM_TABLE[req_reg.form];
  // an undefined case code is timed as worst, the safe overestimate
  wire is_best = (req_reg.case_sel == TIM_CASE_BEST);
  wire is_cache = (req_reg.case_sel == TIM_CASE_CACHE);
  wire is_worst = !is_best && !is_cache;
  wire [7:0] listed = is_best ? entry.best : (is_cache ? entry.cache : entry.worst);
  // both factors widened first: a full list times four clocks does not fit the count width
  wire [TIM_CLK_W-1:0] per_reg = TIM_CLK_W'(entry.per_reg_clk) * TIM_CLK_W'(reg_count);
  wire adds_addr = (entry.addr_kind != TIM_ADDR_NONE);
  wire [TIM_CLK_W-1:0] addr_part = adds_addr ? TIM_CLK_W'(req_reg.addr_clocks) : '0;
  wire [TIM_CNT_W-1:0] rd_n = entry.rd_per_reg ? reg_count : '0;
  wire [TIM_CNT_W-1:0] wr_n = entry.wr_per_reg ? reg_count : '0;

  always_comb begin
    result_next.total = TIM_CLK_W'(listed) + per_reg + addr_part;
    result_next.reads = TIM_CNT_W'(entry.reads) + rd_n;
    result_next.writes = TIM_CNT_W'(entry.writes) + wr_n;
    result_next.prefetches = is_worst ? {1'b0, entry.pf_worst} : 3'h0;
    result_next.addr_kind = entry.addr_kind;
  end

  always_comb begin
    case (state_reg)
      TIM_ST_IDLE: state_next = req_valid ? TIM_ST_LOOKUP : TIM_ST_IDLE;
      TIM_ST_LOOKUP: state_next = TIM_ST_REPORT;
      TIM_ST_REPORT: state_next = TIM_ST_IDLE;
      default: state_next = TIM_ST_IDLE;
    endcase
  end

  assign req_ready = (state_reg == TIM_ST_IDLE);
  assign result_valid = (state_reg == TIM_ST_REPORT);
  assign result = result_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= TIM_ST_IDLE;
      req_reg <= '0;
      result_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (req_valid && req_ready) begin
        req_reg <= req_in;
      end
      if (state_reg == TIM_ST_LOOKUP) begin
        result_reg <= result_next;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_taken;
    req_valid && req_ready;
  endsequence
  sequence s_answer;
    !result_valid ##1 result_valid ##1 !result_valid;
  endsequence

  chk_answer_latency: assert property (s_taken |-> ##1 s_answer)
    else $error("result not one cycle two edges after request");
  chk_triple_inside: assert property (result_valid |->
    (result.reads + result.prefetches + result.writes) <= result.total)
    else $error("bus cycle triple exceeds total");
  chk_worst_prefetch: assert property (result_valid |->
    ((result.prefetches != 3'h0) == is_worst))
    else $error("prefetch count does not follow case");
  chk_load_multi: assert property (result_valid && req_reg.form == TIM_F_MMR_LOAD |->
    result.total == (is_worst ? 9 : 8) + 4 * $countones(req_reg.reg_list) + req_reg.addr_clocks
    && result.reads == $countones(req_reg.reg_list))
    else $error("multiple register load timing wrong");
  chk_store_multi: assert property (result_valid && req_reg.form == TIM_F_MMR_STORE && !is_worst |->
    result.total == 4 + 3 * $countones(req_reg.reg_list) + req_reg.addr_clocks
    && result.reads == 0 && result.writes == $countones(req_reg.reg_list))
    else $error("multiple register store timing wrong");
  chk_store_worst: assert property (result_valid && req_reg.form == TIM_F_MMR_STORE && is_worst |->
    result.total == 5 + 3 * $countones(req_reg.reg_list) + req_reg.addr_clocks
    && result.prefetches == 1)
    else $error("worst multiple register store timing wrong");
  chk_reg_count: assert property (state_reg == TIM_ST_LOOKUP |->
    reg_count == $countones(req_reg.reg_list))
    else $error("register count mismatch");
  chk_fetch_added: assert property (s_taken ##1 (req_reg.form == TIM_F_ALU_TO_REG && is_best) |->
    ##1 result.total == $past(req_in.addr_clocks, 2))
    else $error("fetch addressing time not added");
  chk_alt_calc: assert property (result_valid && req_reg.form == TIM_F_ALT_LOAD && is_best |->
    result.total == 7 + req_reg.addr_clocks)
    else $error("alternate space load timing wrong");
  chk_psw_store: assert property (result_valid && req_reg.form == TIM_F_PSW_TO_MEM |->
    result.total == (is_worst ? 7 : 5) + req_reg.addr_clocks && result.writes == 1)
    else $error("status word store timing wrong");
  chk_imm_mem: assert property (result_valid && req_reg.form == TIM_F_IMM_TO_MEM && is_cache |->
    result.total == 4 + req_reg.addr_clocks && result.writes == 1)
    else $error("immediate to memory timing wrong");
endmodule

// >>> sim/tim_cycle_model_tb_top.sv
`timescale 1ns/10ps
module tim_cycle_model_tb_top
  import tim_pkg::*;
();
  logic clk;
  logic rst_b;
  logic req_valid;
  tim_req_type req_in;
  logic req_ready;
  logic result_valid;
  tim_result_type result;
  int n_errors;
  int n_compared;
  int cycles;

  tim_cycle_model i_dut (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_in(req_in),
    .req_ready(req_ready), .result_valid(result_valid), .result(result));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // own bit count, kept apart from the design's counter
  function automatic int ones(input logic [15:0] v);
    int k;
    k = 0;
    for (int b = 0; b < 16; b++) k += v[b];
    return k;
  endfunction

  // entered at a falling edge; leaves one idle cycle after the result pulse
  task automatic run(input tim_form_type f, input int c, input logic [15:0] rl, input logic [7:0] ac,
    input int et, input int er, input int ep, input int ew, input tim_addr_type ek);
    int i;
    req_in = '{form: f, case_sel: tim_case_type'(c[1:0]), reg_list: rl, addr_clocks: ac};
    req_valid = 1'b1;
    i = 0;
    while (req_ready !== 1'b1 && i < 10) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    i = 0;
    while (result_valid !== 1'b1 && i < 8) begin
      @(negedge clk);
      i++;
    end
    chk("latency", 16'h0001, 16'(i));
    chk("total", 16'(et), {6'h00, result.total});
    chk("reads", 16'(er), {11'h000, result.reads});
    chk("prefetches", 16'(ep), {13'h0000, result.prefetches});
    chk("writes", 16'(ew), {11'h000, result.writes});
    chk("addr_kind", 16'(ek), {13'h0000, result.addr_kind});
    @(negedge clk);
  endtask

  task automatic t_reset();
    chk("ready in reset", 16'h0001, {15'h0000, req_ready});
    chk("valid in reset", 16'h0000, {15'h0000, result_valid});
    chk("total in reset", 16'h0000, {6'h00, result.total});
  endtask

  // case 3 is read as worst; empty and full register lists are the edges
  task automatic t_multi();
    logic [15:0] lists [4];
    int n;
    int w;
    lists = '{16'h0000, 16'h0001, 16'h8421, 16'hFFFF};
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        n = ones(lists[k]);
        w = (c >= 2) ? 1 : 0;
        run(TIM_F_MMR_LOAD, c, lists[k], 8'h06, 14 + w + 4 * n, n, w, 0, TIM_ADDR_CALC_IMM);
        run(TIM_F_MMR_STORE, c, lists[k], 8'h0A, 14 + w + 3 * n, 0, w, n, TIM_ADDR_CALC_IMM);
      end
    end
  endtask

  task automatic t_fixed();
    tim_form_type fs [6] = '{TIM_F_PSW_TO_MEM, TIM_F_ALT_LOAD, TIM_F_ALU_TO_MEM, TIM_F_IMM_TO_MEM,
      TIM_F_QUICK_TO_REG, TIM_F_ALU_TO_REG};
    tim_addr_type ks [6] = '{TIM_ADDR_CALC_EA, TIM_ADDR_CALC_IMM, TIM_ADDR_FETCH_EA, TIM_ADDR_FETCH_IMM,
      TIM_ADDR_NONE, TIM_ADDR_FETCH_EA};
    int tc [6][3] = '{'{5, 5, 7}, '{7, 7, 8}, '{3, 4, 6}, '{3, 4, 6}, '{0, 2, 3}, '{0, 2, 3}};
    int rd [6] = '{0, 1, 0, 0, 0, 0};
    int wr [6] = '{1, 0, 1, 1, 0, 0};
    int ci;
    int add;
    for (int c = 0; c < 4; c++) begin
      ci = (c > 2) ? 2 : c;
      for (int k = 0; k < 6; k++) begin
        add = (ks[k] == TIM_ADDR_NONE) ? 0 : 9;
        run(fs[k], c, 16'h00F0, 8'h09, tc[k][ci] + add, rd[k], (ci == 2) ? 1 : 0, wr[k], ks[k]);
      end
    end
  endtask

  // a request raised while busy must be dropped, and the result must hold
  task automatic t_refuse();
    int seen;
    req_in = '{form: TIM_F_CTL_TO_REG, case_sel: TIM_CASE_BEST, reg_list: 16'h0000, addr_clocks: 8'h00};
    req_valid = 1'b1;
    @(negedge clk);
    req_in.form = TIM_F_MUL_L;
    @(negedge clk);
    req_valid = 1'b0;
    chk("valid after take", 16'h0001, {15'h0000, result_valid});
    chk("total of first", 16'h0003, {6'h00, result.total});
    seen = 0;
    repeat (6) begin
      @(negedge clk);
      if (result_valid === 1'b1) seen++;
    end
    chk("refused pulses", 16'h0000, 16'(seen));
    chk("total held", 16'h0003, {6'h00, result.total});
  endtask

  initial begin
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_in = '0;
    repeat (4) @(negedge clk);
    t_reset();
    rst_b = 1'b1;
    @(negedge clk);
    t_multi();
    t_fixed();
    t_refuse();
    end_sim();
  end
endmodule
